/* File: hdl/mscr_defines.vh */
`ifndef MSCR_DEFINES_VH
`define MSCR_DEFINES_VH

// coprocessor register numbers
`define MSCR_REG_CTRL 4'h1
`define MSCR_REG_TTB 4'h2
`define MSCR_REG_DOMAIN 4'h3
`define MSCR_REG_RSVD4 4'h4
`define MSCR_REG_FSTAT 4'h5
`define MSCR_REG_FADDR 4'h6

// control word bit positions
`define MSCR_CW_MMU_EN 0
`define MSCR_CW_ALIGN_EN 1
`define MSCR_CW_DCACHE_EN 2
`define MSCR_CW_BIG_ENDIAN 7
`define MSCR_CW_SYS_PROT 8
`define MSCR_CW_ROM_PROT 9
`define MSCR_CW_ICACHE_EN 12
`define MSCR_CW_HIGH_VEC 13
`define MSCR_CW_RR 14
`define MSCR_CW_NOT_FASTBUS 30
`define MSCR_CW_ASYNC_CLK 31

// control word: stored bits and bits that read as one
`define MSCR_CW_STORE_MASK 32'hC000_7387
`define MSCR_CW_ONES 32'h0002_1078
`define MSCR_CW_RESET 32'h0000_0000

// translation table base pointer field
`define MSCR_TTB_MASK 32'hFFFF_C000
`define MSCR_TTB_RESET 32'h0000_0000

// domain access
`define MSCR_DOM_RESET 32'h0000_0000
`define MSCR_DOM_NOACCESS 2'h0
`define MSCR_DOM_CLIENT 2'h1
`define MSCR_DOM_RESERVED 2'h2
`define MSCR_DOM_MANAGER 2'h3

// fault status fields
`define MSCR_FS_MASK 32'h0000_00FF
`define MSCR_FS_RESET 32'h0000_0000
`define MSCR_FA_RESET 32'h0000_0000

// exception vector bases
`define MSCR_VEC_LOW 32'h0000_0000
`define MSCR_VEC_HIGH 32'hFFFF_0000

// fault type codes
`define MSCR_FT_ALIGN 4'h1
`define MSCR_FT_TRANS 4'h5
`define MSCR_FT_DOMAIN 4'h9
`define MSCR_FT_PERM 4'hD

`endif

/* File: hdl/mscr_domain_check.v */
`timescale 1ns/1ps
`default_nettype none
`include "mscr_defines.vh"

// ****************************************
// domain field lookup and access decision
// ****************************************
module mscr_domain_check (
	input wire [31:0] dac_i,
	input wire [3:0] domain_i,
	output reg [1:0] field_o,
	output reg domain_fault_o,
	output reg check_perm_o
);
	// selected field, then its meaning
	always @* begin
		field_o = dac_i[{domain_i, 1'b0} +: 2];
		domain_fault_o = 1'b0;
		check_perm_o = 1'b0;
		case (field_o)
			`MSCR_DOM_NOACCESS: domain_fault_o = 1'b1;
			`MSCR_DOM_CLIENT: check_perm_o = 1'b1;
			`MSCR_DOM_MANAGER: check_perm_o = 1'b0;
			// reserved value: treated as no access, software must not rely on it
			default: domain_fault_o = 1'b1;
		endcase
	end
endmodule

`default_nettype wire

/* File: hdl/mscr_regs.v */
// Notes on behaviour
// - control bits 0, 2, 12 enable the MMU, data cache and instruction cache
// - control bit 1 enables alignment fault checking of data accesses
// - control bit 7 selects big endian when set, little endian when clear
// - control bits 8 and 9 are stored and driven out on sys_protect_o and rom_protect_o; no check here uses them
// - control bit 13 moves the vector base from zero to FFFF0000
// - control bit 14 picks round-robin replacement instead of random
// - control bits 31:30 give the clocking mode, async and not-fastbus
// - table base holds bits 31:14; read returns it, write replaces it
// - domain register holds sixteen two-bit fields, domain n at bits 2n+1:2n
// - domain field 00 faults every access; 10 is reserved
// - field 01 checks page permissions; 11 allows all without checking
// - register number 4 is reserved; accesses to it have no defined effect
// - a data abort loads fault type into bits 3:0, domain into 7:4
// - a software write loads the fault status with bits 7:0 of the written value
// - fault address captures the faulting data address; prefetch faults leave it
// - fault address is writable and readable by software
// - four fault kinds: alignment, translation, domain, permission, each aborts
// - instruction fetch faults never update fault status or fault address
`timescale 1ns/1ps
`default_nettype none
`include "mscr_defines.vh"

module mscr_regs (
	input wire clock_i,
	input wire rst_i,
	// coprocessor register transfer from the core
	input wire cp_wr_i,
	input wire cp_rd_i,
	input wire [3:0] cp_reg_i,
	input wire [31:0] cp_wdata_i,
	output reg [31:0] cp_rdata_o,
	// access being checked by the MMU
	input wire acc_valid_i,
	input wire acc_is_fetch_i,
	input wire [31:0] acc_addr_i,
	input wire [1:0] acc_size_i,
	input wire [3:0] acc_domain_i,
	input wire acc_translated_i,
	input wire acc_perm_ok_i,
	output wire abort_o,
	output wire [3:0] abort_type_o,
	// control outputs
	output wire mmu_enable_o,
	output wire align_check_o,
	output wire dcache_enable_o,
	output wire icache_enable_o,
	output wire big_endian_o,
	output wire sys_protect_o,
	output wire rom_protect_o,
	output wire [31:0] vector_base_o,
	output wire round_robin_select_o,
	output wire async_clock_select_o,
	output wire not_fastbus_select_o,
	output wire [1:0] clock_mode_o,
	output wire [31:0] translation_table_base_o
);

	// ****************************************
	// register storage
	// ****************************************
	reg [31:0] system_control_word;
	reg [31:0] translation_table_base;
	reg [31:0] domain_access_control;
	reg [31:0] fault_status;
	reg [31:0] fault_address;

	wire wr_ctrl;
	wire wr_ttb;
	wire wr_dom;
	wire wr_fs;
	wire wr_fa;
	wire [1:0] dom_field;
	wire dom_fault;
	wire dom_check_perm;
	reg align_bad;
	reg [3:0] next_fault_type;
	reg next_fault;
	wire data_abort;

	// write strobes from the register number; number 4 matches none
	assign wr_ctrl = cp_wr_i && (cp_reg_i == `MSCR_REG_CTRL);
	assign wr_ttb = cp_wr_i && (cp_reg_i == `MSCR_REG_TTB);
	assign wr_dom = cp_wr_i && (cp_reg_i == `MSCR_REG_DOMAIN);
	assign wr_fs = cp_wr_i && (cp_reg_i == `MSCR_REG_FSTAT);
	assign wr_fa = cp_wr_i && (cp_reg_i == `MSCR_REG_FADDR);

	// ****************************************
	// control, base and domain registers
	// ****************************************
	// undefined bits are not stored, so a sloppy write cannot leak into them
	always @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			system_control_word <= `MSCR_CW_RESET;
			translation_table_base <= `MSCR_TTB_RESET;
			domain_access_control <= `MSCR_DOM_RESET;
		end else begin
			if (wr_ctrl) begin
				system_control_word <= cp_wdata_i & `MSCR_CW_STORE_MASK;
			end
			if (wr_ttb) begin
				translation_table_base <= cp_wdata_i & `MSCR_TTB_MASK;
			end
			if (wr_dom) begin
				domain_access_control <= cp_wdata_i;
			end
		end
	end

	// ****************************************
	// fault checking
	// ****************************************
	mscr_domain_check u_domain_check (
		.dac_i(domain_access_control),
		.domain_i(acc_domain_i),
		.field_o(dom_field),
		.domain_fault_o(dom_fault),
		.check_perm_o(dom_check_perm)
	);

	// misalignment by access size: 0 byte, 1 halfword, 2 word
	always @* begin
		case (acc_size_i)
			2'h1: align_bad = acc_addr_i[0];
			2'h2: align_bad = |acc_addr_i[1:0];
			default: align_bad = 1'b0;
		endcase
	end

	// priority: alignment, translation, domain, permission
	// alignment does not depend on the MMU enable
	always @* begin
		next_fault = 1'b0;
		next_fault_type = `MSCR_FT_ALIGN;
		if (acc_valid_i) begin
			if (system_control_word[`MSCR_CW_ALIGN_EN] && align_bad && !acc_is_fetch_i) begin
				next_fault = 1'b1;
				next_fault_type = `MSCR_FT_ALIGN;
			end else if (system_control_word[`MSCR_CW_MMU_EN]) begin
				if (!acc_translated_i) begin
					next_fault = 1'b1;
					next_fault_type = `MSCR_FT_TRANS;
				end else if (dom_fault) begin
					next_fault = 1'b1;
					next_fault_type = `MSCR_FT_DOMAIN;
				end else if (dom_check_perm && !acc_perm_ok_i) begin
					// permission input already weighs system and ROM protection
					next_fault = 1'b1;
					next_fault_type = `MSCR_FT_PERM;
				end
			end
		end
	end

	assign abort_o = next_fault;
	assign abort_type_o = next_fault_type;
	assign data_abort = next_fault && !acc_is_fetch_i;

	// ****************************************
	// fault status and fault address
	// ****************************************
	// a fault in the same cycle as a software write wins: the event is not lost
	always @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			fault_status <= `MSCR_FS_RESET;
			fault_address <= `MSCR_FA_RESET;
		end else begin
			if (data_abort) begin
				fault_status <= {24'h00_0000, acc_domain_i, next_fault_type};
				fault_address <= acc_addr_i;
			end else begin
				if (wr_fs) begin
					fault_status <= cp_wdata_i & `MSCR_FS_MASK;
				end
				if (wr_fa) begin
					fault_address <= cp_wdata_i;
				end
			end
		end
	end

	// ****************************************
	// read port
	// ****************************************
	// registered read data; reserved number 4 and unknown numbers read zero
	always @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			cp_rdata_o <= 32'h0000_0000;
		end else if (cp_rd_i) begin
			case (cp_reg_i)
				`MSCR_REG_CTRL: cp_rdata_o <= system_control_word | `MSCR_CW_ONES;
				`MSCR_REG_TTB: cp_rdata_o <= translation_table_base;
				`MSCR_REG_DOMAIN: cp_rdata_o <= domain_access_control;
				`MSCR_REG_RSVD4: cp_rdata_o <= 32'h0000_0000;
				`MSCR_REG_FSTAT: cp_rdata_o <= fault_status;
				`MSCR_REG_FADDR: cp_rdata_o <= fault_address;
				default: cp_rdata_o <= 32'h0000_0000;
			endcase
		end
	end

	// ****************************************
	// control outputs
	// ****************************************
	assign mmu_enable_o = system_control_word[`MSCR_CW_MMU_EN];
	assign align_check_o = system_control_word[`MSCR_CW_ALIGN_EN];
	assign dcache_enable_o = system_control_word[`MSCR_CW_DCACHE_EN];
	assign icache_enable_o = system_control_word[`MSCR_CW_ICACHE_EN];
	assign big_endian_o = system_control_word[`MSCR_CW_BIG_ENDIAN];
	assign sys_protect_o = system_control_word[`MSCR_CW_SYS_PROT];
	assign rom_protect_o = system_control_word[`MSCR_CW_ROM_PROT];
	assign vector_base_o = system_control_word[`MSCR_CW_HIGH_VEC] ?
		`MSCR_VEC_HIGH : `MSCR_VEC_LOW;
	assign round_robin_select_o = system_control_word[`MSCR_CW_RR];
	assign async_clock_select_o = system_control_word[`MSCR_CW_ASYNC_CLK];
	assign not_fastbus_select_o = system_control_word[`MSCR_CW_NOT_FASTBUS];
	assign clock_mode_o = {async_clock_select_o, not_fastbus_select_o};
	assign translation_table_base_o = translation_table_base;

endmodule

`default_nettype wire

/* File: testbench/mscr_regs_chk.sv */
`timescale 1ns/1ps
`default_nettype none
// ****
// register bank port checks
// ****
module mscr_regs_chk (
	input wire logic clock_i,
	input wire logic rst_i,
	input wire logic cp_wr_i,
	input wire logic cp_rd_i,
	input wire logic [3:0] cp_reg_i,
	input wire logic [31:0] cp_wdata_i,
	input wire logic [31:0] cp_rdata_o,
	input wire logic acc_valid_i,
	input wire logic acc_is_fetch_i,
	input wire logic [31:0] acc_addr_i,
	input wire logic [1:0] acc_size_i,
	input wire logic [3:0] acc_domain_i,
	input wire logic abort_o,
	input wire logic [3:0] abort_type_o,
	input wire logic mmu_enable_o,
	input wire logic align_check_o,
	input wire logic [31:0] vector_base_o,
	input wire logic async_clock_select_o,
	input wire logic not_fastbus_select_o,
	input wire logic [1:0] clock_mode_o,
	input wire logic [31:0] translation_table_base_o
);
	// one domain, so clock and reset are given once
	default clocking @(posedge clock_i); endclocking
	default disable iff (rst_i);
	chk_mmu_enable_load: assert property (cp_wr_i && cp_reg_i == 4'h1 |=>
		mmu_enable_o == $past(cp_wdata_i[0])) else $error("mmu enable not loaded");
	chk_vector_base_sel: assert property (cp_wr_i && cp_reg_i == 4'h1 |=>
		vector_base_o == ($past(cp_wdata_i[13]) ? 32'hFFFF0000 : 32'h0))
		else $error("vector base wrong");
	chk_clock_mode_pair: assert property (clock_mode_o ==
		{async_clock_select_o, not_fastbus_select_o}) else $error("clock mode split");
	chk_table_base_load: assert property (cp_wr_i && cp_reg_i == 4'h2 |=>
		translation_table_base_o == ($past(cp_wdata_i) & 32'hFFFFC000))
		else $error("table base wrong");
	chk_align_fault_raise: assert property (acc_valid_i && !acc_is_fetch_i && align_check_o
		&& acc_size_i == 2'h2 && acc_addr_i[1:0] != 2'h0 |-> abort_o && abort_type_o == 4'h1)
		else $error("alignment fault missed");
	chk_unchecked_no_abort: assert property (acc_valid_i && !mmu_enable_o
		&& (acc_is_fetch_i || !align_check_o) |-> !abort_o) else $error("abort with checks off");
	chk_status_capture: assert property (acc_valid_i && !acc_is_fetch_i && abort_o
		##2 cp_rd_i && cp_reg_i == 4'h5 |=> cp_rdata_o[7:0] ==
		{$past(acc_domain_i, 3), $past(abort_type_o, 3)}) else $error("fault status wrong");
	chk_reserved_reads_zero: assert property (cp_rd_i && cp_reg_i == 4'h4 |=>
		cp_rdata_o == 32'h0) else $error("reserved slot not zero");
endmodule
bind mscr_regs mscr_regs_chk mscr_regs_chk_inst (.*);
`default_nettype wire

/* File: testbench/mscr_core_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ****
// core side of the register transfers
// ****
module mscr_core_model (
	input wire logic clock_i,
	output logic cp_wr_o = 1'b0,
	output logic cp_rd_o = 1'b0,
	output logic [3:0] cp_reg_o = 4'h0,
	output logic [31:0] cp_wdata_o = 32'h0,
	input wire logic [31:0] cp_rdata_i
);
	// one-edge write; released data is inverted so no stale value lingers
	task wr(input logic [3:0] r, input logic [31:0] d);
		@(posedge clock_i);
		cp_wr_o <= 1'b1;
		cp_reg_o <= r;
		cp_wdata_o <= d & (r == 4'h1 ? 32'hC0007387 : r == 4'h2 ? 32'hFFFFC000 :
			r == 4'h5 ? 32'hFF : 32'hFFFFFFFF);
		@(posedge clock_i);
		cp_wr_o <= 1'b0;
		cp_wdata_o <= ~d;
		#1;
	endtask
	// data lands on the edge that samples the strobe
	task rd(input logic [3:0] r, output logic [31:0] q);
		@(posedge clock_i);
		cp_rd_o <= 1'b1;
		cp_reg_o <= r;
		@(posedge clock_i);
		cp_rd_o <= 1'b0;
		#1 q = cp_rdata_i;
	endtask
endmodule
`default_nettype wire

/* File: testbench/tb.sv */
`timescale 1ns/1ps
`default_nettype none
// ****
// register bank bench
// ****
module tb;
	logic clock_i = 1'b0;
	logic rst_i = 1'b1;
	logic cp_wr_i, cp_rd_i, abort_o, mmu_enable_o, align_check_o, dcache_enable_o;
	logic icache_enable_o, big_endian_o, sys_protect_o, rom_protect_o, round_robin_select_o;
	logic async_clock_select_o, not_fastbus_select_o;
	logic acc_valid_i = 1'b0, acc_is_fetch_i = 1'b0, acc_translated_i = 1'b1;
	logic acc_perm_ok_i = 1'b1;
	logic [1:0] acc_size_i = 2'h2, clock_mode_o;
	logic [3:0] cp_reg_i, abort_type_o, acc_domain_i = 4'h0;
	logic [31:0] cp_wdata_i, cp_rdata_o, vector_base_o, translation_table_base_o, q, d;
	logic [31:0] acc_addr_i = 32'h0;
	int num_errors = 0;
	int tests_run = 0;
	mscr_regs mscr_regs_inst (.*);
	mscr_core_model core (.clock_i, .cp_wr_o(cp_wr_i), .cp_rd_o(cp_rd_i), .cp_reg_o(cp_reg_i),
		.cp_wdata_o(cp_wdata_i), .cp_rdata_i(cp_rdata_o));
	initial forever #50 clock_i = ~clock_i;
	task chk(input logic [31:0] g, input logic [31:0] e);
		tests_run++;
		if (g !== e) begin
			num_errors++;
			$display("wrong value at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	task summarize;
		$display("checks %0d mismatches %0d", tests_run, num_errors);
		if (num_errors == 0 && tests_run > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	// one access held for one cycle; abort is combinational so look after the edge
	task acc(input logic f, input logic [31:0] a, input logic [3:0] dm, input logic tr,
		input logic ok, input logic [4:0] e);
		@(posedge clock_i);
		acc_valid_i <= 1'b1;
		acc_is_fetch_i <= f;
		acc_addr_i <= a;
		acc_domain_i <= dm;
		acc_translated_i <= tr;
		acc_perm_ok_i <= ok;
		#1 chk({abort_o, abort_o ? abort_type_o : 4'h0}, e);
		@(posedge clock_i);
		acc_valid_i <= 1'b0;
	endtask
	// walk a single one through every control bit
	task t_ctrl;
		for (int i = 0; i < 32; i++) begin
			d = 32'h1 << i;
			core.wr(4'h1, d);
			q = {d[0], d[1], d[2], d[12], d[7], d[8], d[9], d[14], d[31], d[30], d[31], d[30]};
			chk({mmu_enable_o, align_check_o, dcache_enable_o, icache_enable_o, big_endian_o,
				sys_protect_o, rom_protect_o, round_robin_select_o, async_clock_select_o,
				not_fastbus_select_o, clock_mode_o}, q);
			chk(vector_base_o, d[13] ? 32'hFFFF0000 : 32'h0);
			core.rd(4'h1, q);
			chk(q, (d & 32'hC0007387) | 32'h00021078);
		end
		$display("control word test done");
	endtask
	task t_regs;
		core.wr(4'h2, 32'hA5A5FFFF);
		chk(translation_table_base_o, 32'hA5A5C000);
		core.rd(4'h2, q);
		chk(q, 32'hA5A5C000);
		core.wr(4'h3, 32'h9C36A5F0);
		core.rd(4'h3, q);
		chk(q, 32'h9C36A5F0);
		core.wr(4'h5, 32'h5A);
		core.rd(4'h5, q);
		chk(q, 32'h5A);
		core.wr(4'h6, 32'h12345678);
		core.wr(4'h4, 32'hFFFFFFFF);
		core.rd(4'h4, q);
		chk(q, 32'h0);
		core.rd(4'h6, q);
		chk(q, 32'h12345678);
		$display("register test done");
	endtask
	// domain 3 no access, 5 client, 7 manager
	task t_fault;
		core.wr(4'h3, 32'h5555D515);
		core.wr(4'h1, 32'h3);
		acc(1'b0, 32'h102, 4'h5, 1'b0, 1'b1, 5'h11);
		core.rd(4'h5, q);
		chk(q, 32'h51);
		core.rd(4'h6, q);
		chk(q, 32'h102);
		acc(1'b1, 32'h200, 4'h3, 1'b1, 1'b1, 5'h19);
		core.rd(4'h5, q);
		chk(q, 32'h51);
		core.rd(4'h6, q);
		chk(q, 32'h102);
		acc(1'b0, 32'h300, 4'h5, 1'b0, 1'b1, 5'h15);
		acc(1'b0, 32'h304, 4'h3, 1'b1, 1'b1, 5'h19);
		acc(1'b0, 32'h308, 4'h5, 1'b1, 1'b0, 5'h1D);
		core.rd(4'h5, q);
		chk(q, 32'h5D);
		acc(1'b0, 32'h30C, 4'h7, 1'b1, 1'b0, 5'h00);
		// halfword size: only bit 0 makes it misaligned
		acc_size_i <= 2'h1;
		acc(1'b0, 32'h101, 4'h7, 1'b1, 1'b1, 5'h11);
		acc(1'b0, 32'h102, 4'h7, 1'b1, 1'b1, 5'h00);
		acc_size_i <= 2'h2;
		core.wr(4'h1, 32'h0);
		acc(1'b0, 32'h102, 4'h3, 1'b0, 1'b0, 5'h00);
		acc(1'b1, 32'h102, 4'h3, 1'b0, 1'b0, 5'h00);
		$display("fault test done");
	endtask
	// a hang is cut short and counted
	initial begin
		#5ms;
		num_errors++;
		summarize;
	end
	initial begin
		repeat (2) @(posedge clock_i);
		rst_i <= 1'b0;
		t_ctrl;
		t_regs;
		t_fault;
		summarize;
	end
endmodule
`default_nettype wire
